// file: radio_cfg_pkg.sv
/*
  Shared constants of the radio configuration store: register offsets,
  field positions, reset and factory values, and the accepted argument sets.
  Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
*/
`default_nettype none

package radio_cfg_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIAGNOSTIC_PORT_RATE = 8'h04;
  localparam logic [7:0] OFS_HOP = 8'h08;
  localparam logic [7:0] OFS_POWER = 8'h0C;
  localparam logic [7:0] OFS_COMMAND = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_DATA_PORT = 8'h18;
  localparam logic [7:0] OFS_CTS = 8'h1C;
  localparam logic [7:0] OFS_ALARM_MASK = 8'h20;
  localparam logic [7:0] OFS_MISC = 8'h24;
  localparam logic [7:0] OFS_EXT = 8'h28;
  localparam logic [7:0] OFS_ARQ = 8'h2C;
  localparam logic [7:0] OFS_MESSAGE = 8'h40;
  localparam logic [7:0] OFS_SITE = 8'h60;

  // Control register fields
  localparam int unsigned CTRL_DIAGNOSTIC_PORT_EN_BIT = 0;
  localparam int unsigned CTRL_ROOT_BIT = 1;
  localparam int unsigned CTRL_FEC_BIT = 2;
  localparam int unsigned CTRL_LED_BIT = 3;
  localparam int unsigned CTRL_MODE_LSB = 4;
  localparam int unsigned CTRL_PORT_BIT = 6;

  // Command register bits (write-only strobes)
  localparam int unsigned CMD_RESTORE_BIT = 0;
  localparam int unsigned CMD_KEY_BIT = 1;
  localparam int unsigned CMD_UNKEY_BIT = 2;
  localparam int unsigned CMD_DIAGNOSTIC_PORT_ON_BIT = 3;

  // Status register bits
  localparam int unsigned STAT_ERR_BIT = 0;
  localparam int unsigned STAT_KEYED_BIT = 1;
  localparam int unsigned STAT_TTL_BIT = 2;
  localparam int unsigned STAT_SYNC_BIT = 3;
  localparam int unsigned STAT_SETUP_BIT = 4;

  // Operating modes
  typedef enum logic [1:0] {MODE_REMOTE, MODE_MASTER, MODE_EXTENSION, MODE_BAD} op_mode_t;

  // Line rates in bits per second
  localparam logic [16:0] RATE_1200 = 17'h0_04B0;
  localparam logic [16:0] RATE_2400 = 17'h0_0960;
  localparam logic [16:0] RATE_4800 = 17'h0_12C0;
  localparam logic [16:0] RATE_9600 = 17'h0_2580;
  localparam logic [16:0] RATE_19200 = 17'h0_4B00;
  localparam logic [16:0] RATE_38400 = 17'h0_9600;
  localparam logic [16:0] RATE_57600 = 17'h0_E100;
  localparam logic [16:0] RATE_115200 = 17'h1_C200;

  // Reset and factory values of the main settings
  localparam logic [7:0] CTRL_RST = 8'h0D;
  localparam logic [16:0] DIAGNOSTIC_PORT_RATE_RST = RATE_19200;
  localparam logic [7:0] HOP_SHORT_MS = 8'h07;
  localparam logic [7:0] HOP_LONG_MS = 8'h1C;
  localparam logic [7:0] PWR_MIN_DBM = 8'h14;
  localparam logic [7:0] PWR_MAX_DBM = 8'h1E;
  localparam logic [7:0] PWR_RST_DBM = 8'h1E;

  // Payload port word: baud [16:0], eight bits 17, parity [19:18], two stop 20, cts key 21
  localparam int unsigned DP_EIGHT_BIT = 17;
  localparam int unsigned DP_PARITY_LSB = 18;
  localparam int unsigned DP_TWO_STOP_BIT = 20;
  localparam logic [31:0] DATA_PORT_RST = 32'h0002_2580;
  localparam logic [31:0] DATA_PORT_MASK = 32'h003F_FFFF;

  // Clear-to-send word: delay [7:0], hold time [31:16]
  localparam logic [31:0] CTS_RST = 32'h0000_0000;
  localparam logic [31:0] CTS_MASK = 32'hFFFF_00FF;
  localparam logic [15:0] CTS_HOLD_MAX = 16'hEA60;

  localparam logic [31:0] ALARM_MASK_RST = 32'hFFFF_FFFF;

  // Misc word: rx timeout [10:0] (all ones = none), sleep 12, skip zones [23:16], buffering 24
  localparam logic [31:0] MISC_RST = 32'h0000_07FF;
  localparam logic [31:0] MISC_MASK = 32'h01FF_17FF;
  localparam logic [31:0] MISC_MASTER_FIELDS = 32'h01FF_0000;
  localparam logic [10:0] RECEIVE_TIMEOUT_MINUTES_NONE = 11'h7FF;
  localparam logic [10:0] RECEIVE_TIMEOUT_MINUTES_MAX = 11'h5A0;

  // Extension word: extended address [15:0], sync source map [31:16]
  localparam logic [31:0] EXT_RST = 32'h0000_0000;

  // Link-layer counts: retry [3:0], repeat [11:8]
  localparam logic [31:0] ARQ_RST = 32'h0000_030A;
  localparam logic [31:0] ARQ_MASK = 32'h0000_0F0F;
  localparam logic [3:0] ARQ_MAX = 4'hA;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

`default_nettype wire

// file: radio_config_command_store.sv
/*
  Configuration store and command handler of the data radio, reached over AXI4-Lite.
  Holds the diagnostic link, node type, error correction, hop time, LED, mode,
  port, power, owner texts and the factory-restorable payload settings.
  Assumes the sync, setup and TTL-fit inputs are synchronous to aclk.
*/
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module radio_config_command_store
  import radio_cfg_pkg::*;
#(
  parameter int unsigned TEXT_CHARS = 30
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic master_synced,
  input wire logic setup_mode,
  input wire logic ttl_only_fit,
  input wire logic [3:0] led_activity,
  output logic diagnostic_port_link_setting,
  output logic [16:0] diagnostic_port_rate,
  output logic diagnostic_port_node_type,
  output logic fec_enable,
  output logic [7:0] hop_interval,
  output logic [1:0] op_mode,
  output logic port_rs485,
  output logic [7:0] rf_output_level,
  output logic tx_keyed,
  output logic [3:0] led_drive,
  output logic [31:0] data_port_cfg,
  output logic [31:0] cts_cfg,
  output logic [31:0] alarm_output_mask,
  output logic [31:0] misc_cfg,
  output logic [31:0] extension_cfg,
  output logic [31:0] arq_cfg
);

  localparam int unsigned TEXT_WORDS = 8;

  // Text memory holds two strings of TEXT_WORDS words each
  initial
  begin
    if (TEXT_CHARS < 1 || TEXT_CHARS > 4 * TEXT_WORDS)
    begin
      $error("TEXT_CHARS must lie between 1 and 32");
    end
  end

  logic aw_full_q;
  logic [7:0] aw_addr_q;
  logic w_full_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] ctrl_q;
  logic [16:0] diagnostic_port_rate_q;
  logic [7:0] hop_q;
  logic [7:0] pwr_q;
  logic keyed_q;
  logic err_q;
  logic [3:0] led_q;
  logic [31:0] data_port_q;
  logic [31:0] cts_q;
  logic [31:0] alarm_output_mask_q;
  logic [31:0] misc_q;
  logic [31:0] ext_q;
  logic [31:0] arq_q;
  logic [31:0] text_q [2 * TEXT_WORDS];

  // Bus handshake decode: one write and one read in flight at most
  wire wr_go = aw_full_q & w_full_q & ~bvalid_q;
  wire rd_go = s_axi_arvalid & arready_q;
  wire [31:0] wd = w_data_q;
  wire [7:0] wa = {aw_addr_q[7:2], 2'b00};
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire is_master = ctrl_q[CTRL_MODE_LSB +: 2] == MODE_MASTER;
  wire hop_readable = is_master | master_synced;
  wire wr_text = wa[7:6] == 2'b01;
  wire rd_text = ra[7:6] == 2'b01;
  wire [3:0] wr_text_idx = wa[5:2];
  wire [3:0] rd_text_idx = ra[5:2];

  // Argument checks; status, alarm mask, extension and text writes take none
  wire rate_ok = wd[16:0] == RATE_1200 || wd[16:0] == RATE_4800 || wd[16:0] == RATE_9600
    || wd[16:0] == RATE_19200 || wd[16:0] == RATE_38400 || wd[16:0] == RATE_57600
    || wd[16:0] == RATE_115200;
  wire data_rate_ok = rate_ok || wd[16:0] == RATE_2400;
  wire hop_ok = wd[7:0] == HOP_SHORT_MS || wd[7:0] == HOP_LONG_MS;
  wire pwr_ok = wd[7:0] >= PWR_MIN_DBM && wd[7:0] <= PWR_MAX_DBM;
  wire fec_change = wd[CTRL_FEC_BIT] != ctrl_q[CTRL_FEC_BIT];
  wire ctrl_ok = wd[CTRL_MODE_LSB +: 2] != MODE_BAD && (is_master || !fec_change);
  wire [2:0] fmt = {wd[DP_EIGHT_BIT], wd[DP_PARITY_LSB +: 2]};
  // Seven bits with no parity, and two stops with parity on eight bits, are unsupported
  wire fmt_ok = wd[DP_PARITY_LSB +: 2] != 2'b11 && fmt != 3'b000
    && !(wd[DP_EIGHT_BIT] && wd[DP_TWO_STOP_BIT] && wd[DP_PARITY_LSB +: 2] != 2'b00);
  wire cts_ok = wd[31:16] <= CTS_HOLD_MAX;
  wire misc_ok = (wd[10:0] <= RECEIVE_TIMEOUT_MINUTES_MAX || wd[10:0] == RECEIVE_TIMEOUT_MINUTES_NONE)
    && (is_master || (wd & MISC_MASTER_FIELDS) == (misc_q & MISC_MASTER_FIELDS));
  wire arq_ok = is_master && wd[3:0] <= ARQ_MAX && wd[11:8] <= ARQ_MAX;
  wire key_ok = !wd[CMD_KEY_BIT] || setup_mode;

  // Per-address acceptance; anything else answers SLVERR and changes only the error flag
  wire at_ctrl = wa == OFS_CTRL;
  wire at_rate = wa == OFS_DIAGNOSTIC_PORT_RATE;
  wire at_hop = wa == OFS_HOP;
  wire at_pwr = wa == OFS_POWER;
  wire at_cmd = wa == OFS_COMMAND;
  wire at_stat = wa == OFS_STATUS;
  wire at_dp = wa == OFS_DATA_PORT;
  wire at_cts = wa == OFS_CTS;
  wire at_alarm_output_mask = wa == OFS_ALARM_MASK;
  wire at_misc = wa == OFS_MISC;
  wire at_ext = wa == OFS_EXT;
  wire at_arq = wa == OFS_ARQ;
  wire wr_ok = (at_ctrl && ctrl_ok) || (at_rate && rate_ok) || (at_hop && hop_ok && is_master)
    || (at_pwr && pwr_ok) || (at_cmd && key_ok) || at_stat || (at_dp && data_rate_ok && fmt_ok)
    || (at_cts && cts_ok) || at_alarm_output_mask || (at_misc && misc_ok) || at_ext || (at_arq && arq_ok)
    || wr_text;
  wire wr_acc = wr_go & wr_ok;
  wire restore = wr_acc & at_cmd & wd[CMD_RESTORE_BIT];
  wire master_restore = restore & is_master;
  wire err_set = wr_go & ~wr_ok;
  wire err_clr = wr_acc & at_stat & wd[STAT_ERR_BIT];

  // Write address and data are taken independently and held until the response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_go)
      begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_full_q)
      begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (wr_go)
      begin
        w_full_q <= 1'b0;
      end
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  // Read side: a hop or link-count read on an unsynchronized remote is refused
  wire [31:0] stat_word = {27'h000_0000, setup_mode, master_synced, ttl_only_fit, keyed_q, err_q};
  wire rd_hidden = (ra == OFS_HOP || ra == OFS_ARQ) && !hop_readable;
  // A TTL-only unit reports TTL through the status word; the port bit reads zero then
  wire [7:0] ctrl_view = ttl_only_fit ? (ctrl_q & ~(8'h01 << CTRL_PORT_BIT)) : ctrl_q;
  logic [31:0] rd_word;
  logic rd_map;
  always_comb
  begin
    rd_map = 1'b1;
    rd_word = 32'h0000_0000;
    case (ra)
      OFS_CTRL: rd_word = {24'h00_0000, ctrl_view};
      OFS_DIAGNOSTIC_PORT_RATE: rd_word = {15'h0000, diagnostic_port_rate_q};
      OFS_HOP: rd_word = {24'h00_0000, hop_q};
      OFS_POWER: rd_word = {24'h00_0000, pwr_q};
      OFS_COMMAND: rd_word = 32'h0000_0000;
      OFS_STATUS: rd_word = stat_word;
      OFS_DATA_PORT: rd_word = data_port_q;
      OFS_CTS: rd_word = cts_q;
      OFS_ALARM_MASK: rd_word = alarm_output_mask_q;
      OFS_MISC: rd_word = misc_q;
      OFS_EXT: rd_word = ext_q;
      OFS_ARQ: rd_word = arq_q;
      default:
      begin
        rd_map = rd_text;
        rd_word = rd_text ? text_q[rd_text_idx] : 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      arready_q <= !rvalid_q && !rd_go && !arready_q;
      if (rd_go)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= (rd_map && !rd_hidden) ? rd_word : 32'h0000_0000;
        rresp_q <= (rd_map && !rd_hidden) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Main settings; restore has priority over an ordinary write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= CTRL_RST;
      diagnostic_port_rate_q <= DIAGNOSTIC_PORT_RATE_RST;
      pwr_q <= PWR_RST_DBM;
    end
    else if (restore)
    begin
      // Mode is kept so that a master still restores its network-wide values
      ctrl_q <= (CTRL_RST & 8'h4F) | (ctrl_q & 8'h30);
      diagnostic_port_rate_q <= DIAGNOSTIC_PORT_RATE_RST;
      pwr_q <= PWR_RST_DBM;
    end
    else if (wr_acc)
    begin
      if (at_ctrl)
      begin
        ctrl_q <= wd[7:0] & 8'h7F;
      end
      if (at_cmd && wd[CMD_DIAGNOSTIC_PORT_ON_BIT])
      begin
        ctrl_q[CTRL_DIAGNOSTIC_PORT_EN_BIT] <= 1'b1;
      end
      if (at_rate)
      begin
        diagnostic_port_rate_q <= wd[16:0];
      end
      if (at_pwr)
      begin
        pwr_q <= wd[7:0];
      end
    end
  end

  // Payload and extension settings, restored on every radio
  always_ff @(posedge aclk)
  begin
    if (!aresetn || restore)
    begin
      data_port_q <= DATA_PORT_RST;
      cts_q <= CTS_RST;
      alarm_output_mask_q <= ALARM_MASK_RST;
      ext_q <= EXT_RST;
    end
    else if (wr_acc)
    begin
      data_port_q <= at_dp ? (wd & DATA_PORT_MASK) : data_port_q;
      cts_q <= at_cts ? (wd & CTS_MASK) : cts_q;
      alarm_output_mask_q <= at_alarm_output_mask ? wd : alarm_output_mask_q;
      ext_q <= at_ext ? wd : ext_q;
    end
  end

  // Network-wide settings; the master-only part reloads only on a master
  always_ff @(posedge aclk)
  begin
    if (!aresetn || master_restore)
    begin
      hop_q <= HOP_SHORT_MS;
      arq_q <= ARQ_RST;
      misc_q <= MISC_RST;
    end
    else if (restore)
    begin
      misc_q <= (misc_q & MISC_MASTER_FIELDS) | (MISC_RST & ~MISC_MASTER_FIELDS);
    end
    else if (wr_acc)
    begin
      hop_q <= at_hop ? wd[7:0] : hop_q;
      arq_q <= at_arq ? (wd & ARQ_MASK) : arq_q;
      misc_q <= at_misc ? (wd & MISC_MASK) : misc_q;
    end
  end

  // Transmitter key: drops on unkey, on leaving setup, or on restore
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      keyed_q <= 1'b0;
    end
    else if (!setup_mode || (wr_acc && at_cmd && (wd[CMD_UNKEY_BIT] || restore)))
    begin
      keyed_q <= 1'b0;
    end
    else if (wr_acc && at_cmd && wd[CMD_KEY_BIT])
    begin
      keyed_q <= 1'b1;
    end
  end

  // Sticky error flag: a new refusal wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      err_q <= 1'b0;
    end
    else
    begin
      err_q <= err_set | (err_q & ~err_clr);
    end
  end

  // LED outputs are gated by the enable bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      led_q <= 4'h0;
    end
    else
    begin
      led_q <= led_activity & {4{ctrl_q[CTRL_LED_BIT]}};
    end
  end

  // Owner text words; bytes past the character limit are never stored
  genvar gi;
  generate
    for (gi = 0; gi < 2 * TEXT_WORDS; gi = gi + 1)
    begin : g_text
      localparam int unsigned BASE = (gi % TEXT_WORDS) * 4;
      wire [3:0] lane_ok = {BASE + 3 < TEXT_CHARS, BASE + 2 < TEXT_CHARS,
        BASE + 1 < TEXT_CHARS, BASE < TEXT_CHARS};
      wire [3:0] lane_we = {4{wr_acc && wr_text && wr_text_idx == 4'(gi)}} & w_strb_q & lane_ok;
      always_ff @(posedge aclk)
      begin
        for (int b = 0; b < 4; b++)
        begin
          if (!aresetn)
          begin
            text_q[gi][8*b +: 8] <= 8'h00;
          end
          else if (lane_we[b])
          begin
            text_q[gi][8*b +: 8] <= wd[8*b +: 8];
          end
        end
      end
    end
  endgenerate

  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready = ~w_full_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign diagnostic_port_link_setting = ctrl_q[CTRL_DIAGNOSTIC_PORT_EN_BIT];
  assign diagnostic_port_rate = diagnostic_port_rate_q;
  assign diagnostic_port_node_type = ctrl_q[CTRL_ROOT_BIT];
  assign fec_enable = ctrl_q[CTRL_FEC_BIT];
  assign hop_interval = hop_q;
  assign op_mode = ctrl_q[CTRL_MODE_LSB +: 2];
  assign port_rs485 = ctrl_q[CTRL_PORT_BIT];
  assign rf_output_level = pwr_q;
  assign tx_keyed = keyed_q;
  assign led_drive = led_q;
  assign data_port_cfg = data_port_q;
  assign cts_cfg = cts_q;
  assign alarm_output_mask = alarm_output_mask_q;
  assign misc_cfg = misc_q;
  assign extension_cfg = ext_q;
  assign arq_cfg = arq_q;

  // Checks on the stored settings and the bus answers
  a_rate_legal: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && at_rate && !rate_ok |=> $stable(diagnostic_port_rate_q) && bresp_q == RESP_SLVERR)
    else $error("illegal diagnostic rate was stored");
  a_hop_values: assert property (@(posedge aclk) disable iff (!aresetn)
    hop_q == HOP_SHORT_MS || hop_q == HOP_LONG_MS)
    else $error("hop time outside 7 or 28");
  a_hop_remote_wr: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && at_hop && !is_master |=> $stable(hop_q) ##0 s_axi_bresp == RESP_SLVERR)
    else $error("remote accepted a hop time write");
  a_key_setup: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_keyed |-> $past(setup_mode))
    else $error("transmitter keyed outside setup");
  a_unkey_drops: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_acc && at_cmd && wd[CMD_UNKEY_BIT] |=> !tx_keyed [*2])
    else $error("unkey did not drop the transmitter");
  a_led_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_q[CTRL_LED_BIT] |=> led_drive == 4'h0)
    else $error("LED driven while disabled");
  a_power_range: assert property (@(posedge aclk) disable iff (!aresetn)
    rf_output_level >= PWR_MIN_DBM && rf_output_level <= PWR_MAX_DBM)
    else $error("power outside 20 to 30 dBm");
  a_restore_load: assert property (@(posedge aclk) disable iff (!aresetn)
    restore |=> data_port_cfg == DATA_PORT_RST && alarm_output_mask == ALARM_MASK_RST
    && extension_cfg == EXT_RST && diagnostic_port_rate == DIAGNOSTIC_PORT_RATE_RST)
    else $error("restore did not load factory values");
  a_master_restore: assert property (@(posedge aclk) disable iff (!aresetn)
    master_restore |=> hop_interval == HOP_SHORT_MS && arq_cfg == ARQ_RST && fec_enable)
    else $error("master restore incomplete");
  a_err_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    err_set |=> err_q)
    else $error("refused write did not raise the error flag");

endmodule

`default_nettype wire

// file: axi_host.sv
/* Register bus master standing in for the operator console.
   Assumes one clock; waits on the slave's own handshakes. */
`timescale 1ns/1ps
`default_nettype none
module axi_host (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr = 8'h00,
  output logic s_axi_awvalid = 1'b0,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata = 32'h0,
  output logic s_axi_wvalid = 1'b0,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready = 1'b0,
  output logic [7:0] s_axi_araddr = 8'h00,
  output logic s_axi_arvalid = 1'b0,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready = 1'b0
);
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk); // Spare edge so no strobe is set twice in one step
  endtask
  // Read: data and response taken at the edge that shows rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// file: tb.sv
/* Bench of the radio configuration store: a table of register accesses,
   then hand-written key, LED and port cases. Assumes axi_host drives the bus. */
`timescale 1ns/1ps
`default_nettype none
module tb
  import radio_cfg_pkg::*;
;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] v; logic [1:0] r;} row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic master_synced = 1'b0, setup_mode = 1'b0, ttl_only_fit = 1'b0;
  logic [3:0] led_activity = 4'hF, s_axi_wstrb = 4'hF, led_drive;
  logic [7:0] s_axi_awaddr, s_axi_araddr, hop_interval, rf_output_level;
  logic [31:0] s_axi_wdata, s_axi_rdata, data_port_cfg, cts_cfg, alarm_output_mask;
  logic [31:0] misc_cfg, extension_cfg, arq_cfg, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, op_mode, resp;
  logic [16:0] diagnostic_port_rate;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic diagnostic_port_link_setting, diagnostic_port_node_type, fec_enable, port_rs485, tx_keyed;
  int fail_count = 0, tests_run = 0;
  // Access, address, data written or read back, response; root never set: one per network
  // Console reads back the rate it programmed
  // Throughput stays low, so error correction is never turned off
  row_t rows [0:22] = '{'{1'h0, 8'h00, 32'h0D, 2'h0}, '{1'h0, 8'h08, 32'h00, 2'h2},
    '{1'h1, 8'h08, 32'h1C, 2'h2}, '{1'h1, 8'h04, 32'h12C0, 2'h0}, '{1'h1, 8'h04, 32'h0960, 2'h2},
    '{1'h1, 8'h00, 32'h1C, 2'h0}, '{1'h1, 8'h10, 32'h08, 2'h0}, '{1'h0, 8'h00, 32'h1D, 2'h0},
    '{1'h0, 8'h04, 32'h12C0, 2'h0}, '{1'h1, 8'h08, 32'h1C, 2'h0}, '{1'h0, 8'h08, 32'h1C, 2'h0},
    '{1'h1, 8'h08, 32'h0E, 2'h2}, '{1'h1, 8'h0C, 32'h13, 2'h2}, '{1'h1, 8'h0C, 32'h14, 2'h0},
    '{1'h1, 8'h00, 32'h30, 2'h2}, '{1'h1, 8'h40, 32'h6463_6261, 2'h0},
    '{1'h0, 8'h40, 32'h6463_6261, 2'h0}, '{1'h0, 8'h30, 32'h00, 2'h2}, '{1'h1, 8'h20, 32'h00, 2'h0},
    '{1'h1, 8'h28, 32'h1234_5678, 2'h0}, '{1'h1, 8'h10, 32'h01, 2'h0},
    '{1'h0, 8'h0C, 32'h1E, 2'h0}, '{1'h0, 8'h00, 32'h1D, 2'h0}};
  radio_config_command_store #(.TEXT_CHARS(30)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .master_synced, .setup_mode, .ttl_only_fit, .led_activity, .diagnostic_port_link_setting,
    .diagnostic_port_rate, .diagnostic_port_node_type, .fec_enable, .hop_interval, .op_mode, .port_rs485, .rf_output_level,
    .tx_keyed, .led_drive, .data_port_cfg, .cts_cfg, .alarm_output_mask, .misc_cfg, .extension_cfg, .arq_cfg);
  axi_host u_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Counted comparison; four-state so an unknown never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // 50 ns clock
  initial
  begin
    forever #25 aclk = ~aclk;
  end
  // Cuts a hang short; the whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    results();
  end
  // Main sequence
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(diagnostic_port_rate), 32'(RATE_19200));
    chk(32'({diagnostic_port_link_setting, diagnostic_port_node_type, fec_enable, op_mode}), 32'h14);
    foreach (rows[i])
    begin
      if (rows[i].w)
        u_host.wr(rows[i].a, rows[i].v, resp);
      else
      begin
        u_host.rd(rows[i].a, rd, resp);
        chk(rd, rows[i].v);
      end
      chk(32'(resp), 32'(rows[i].r));
    end
    chk(data_port_cfg, DATA_PORT_RST);
    chk(alarm_output_mask ^ extension_cfg, ALARM_MASK_RST);
    chk(arq_cfg, ARQ_RST);
    // Keying refused outside setup, then key and unkey inside it
    u_host.wr(OFS_COMMAND, 32'h02, resp);
    chk(32'({resp, tx_keyed}), 32'h4);
    setup_mode <= 1'b1;
    u_host.wr(OFS_COMMAND, 32'h02, resp);
    chk(32'({resp, tx_keyed}), 32'h1);
    u_host.wr(OFS_COMMAND, 32'h04, resp);
    chk(32'(tx_keyed), 32'h0);
    chk(32'(led_drive), 32'hF);
    u_host.wr(OFS_CTRL, 32'h15, resp);
    repeat (2) @(posedge aclk);
    chk(32'(led_drive), 32'h0);
    u_host.wr(OFS_CTRL, 32'h4D, resp);
    chk(32'({port_rs485, op_mode}), 32'h4);
    ttl_only_fit <= 1'b1;
    master_synced <= 1'b1;
    u_host.rd(OFS_STATUS, rd, resp);
    chk(32'(rd[STAT_TTL_BIT]), 32'h1);
    u_host.rd(OFS_HOP, rd, resp);
    chk(rd, 32'h07);
    results();
  end
endmodule
`default_nettype wire
